//--- logic/port0_mode_regs.vh
// Register offsets, field layout and reset values of the port 0 pin-mode block
`ifndef PORT0_MODE_REGS_VH
`define PORT0_MODE_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W              8
`define OFS_MODE_UPPER      8'he0
`define OFS_MODE_LOWER      8'he1

// ----------------------------------------------------------------
// Reset values and read filler
// ----------------------------------------------------------------
`define RST_MODE_UPPER      8'h00
`define RST_MODE_LOWER      8'h00
`define RD_UNMAPPED         8'h00

// ----------------------------------------------------------------
// Mode field encodings
// ----------------------------------------------------------------
`define MODE_W              2
`define MODE_SCHMITT        2'h0
`define MODE_PULLUP         2'h1
`define MODE_OPEN_DRAIN     2'h2
`define MODE_PUSH_PULL      2'h3

`endif

//--- logic/pin_mode_cell.v
// One pin's mode decode and output stage, registered
`timescale 1ns/1ns
`include "port0_mode_regs.vh"

module pin_mode_cell
(
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_n,
  // Mode field and output data
  input  wire [`MODE_W-1:0]   mode,
  input  wire                 out_data,
  // Pad controls
  output reg                  pad_out,
  output reg                  pad_oe,
  output reg                  pad_pullup,
  output reg                  pad_schmitt
);

  reg pad_out_d;
  reg pad_oe_d;
  reg pad_pullup_d;
  reg pad_schmitt_d;

  always @*
  begin
    pad_out_d     = 1'b0;
    pad_oe_d      = 1'b0;
    pad_pullup_d  = 1'b0;
    pad_schmitt_d = 1'b1;
    case (mode)
      // RULE1 - plain Schmitt input
      `MODE_SCHMITT:
      begin
        pad_schmitt_d = 1'b1;
      end
      // RULE2 - input with pull-up
      `MODE_PULLUP:
      begin
        pad_pullup_d = 1'b1;
      end
      // RULE3 - drive low only
      `MODE_OPEN_DRAIN:
      begin
        pad_schmitt_d = 1'b0;
        pad_out_d     = 1'b0;
        pad_oe_d      = ~out_data;
      end
      // RULE4 - drive both levels
      `MODE_PUSH_PULL:
      begin
        pad_schmitt_d = 1'b0;
        pad_out_d     = out_data;
        pad_oe_d      = 1'b1;
      end
      default:
      begin
        pad_schmitt_d = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out     <= 1'b0;
      pad_oe      <= 1'b0;
      pad_pullup  <= 1'b0;
      pad_schmitt <= 1'b1;
    end
    else
    begin
      pad_out     <= pad_out_d;
      pad_oe      <= pad_oe_d;
      pad_pullup  <= pad_pullup_d;
      pad_schmitt <= pad_schmitt_d;
    end
  end

endmodule

//--- logic/port0_pin_mode_control.v
// Port 0 pin-mode control: two mode registers and eight pin stages
//
// Operation
// RULE1 - Mode 00: Schmitt input, no pull-up, driver off
// RULE2 - Mode 01: Schmitt input with pull-up enabled
// RULE3 - Mode 10: open-drain output, pulls low only
// RULE4 - Mode 11: push-pull output drives both levels
// RULE5 - Upper register pins 7-4, lower 3-0; reset zero
`timescale 1ns/1ns
`include "port0_mode_regs.vh"

module port0_pin_mode_control
#(
  parameter PINS = 8
)
(
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_n,
  // Register port
  input  wire [`ADDR_W-1:0]   reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  // Port output data from the data register
  input  wire [PINS-1:0]      pin_out_data,
  // Pad controls
  output wire [PINS-1:0]      pin_out,
  output wire [PINS-1:0]      pin_oe,
  output wire [PINS-1:0]      pin_pullup_en,
  output wire [PINS-1:0]      pin_schmitt_en,
  // Mode readback
  output reg  [2*PINS-1:0]    pin_mode
);

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  reg [7:0] mode_upper_q;
  reg [7:0] mode_lower_q;
  reg [7:0] reg_rdata_d;

  // RULE5 - reset to Schmitt inputs
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_upper_q <= `RST_MODE_UPPER;
      mode_lower_q <= `RST_MODE_LOWER;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFS_MODE_UPPER)
        mode_upper_q <= reg_wdata;
      if (reg_addr == `OFS_MODE_LOWER)
        mode_lower_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @*
  begin
    case (reg_addr)
      `OFS_MODE_UPPER: reg_rdata_d = mode_upper_q;
      `OFS_MODE_LOWER: reg_rdata_d = mode_lower_q;
      default:         reg_rdata_d = `RD_UNMAPPED;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `RD_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= reg_rdata_d;
    else
      reg_rdata <= `RD_UNMAPPED;
  end

  // ----------------------------------------------------------------
  // Pin stages
  // ----------------------------------------------------------------
  // RULE5 - upper byte holds pins 7-4
  wire [15:0] mode_all = {mode_upper_q, mode_lower_q};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_mode <= {2*PINS{1'b0}};
    else
      pin_mode <= mode_all[2*PINS-1:0];
  end

  // Pad stage is registered, so a mode write reaches the pad one edge later
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1)
    begin : g_pin
      pin_mode_cell u_cell
      (
        .clk         (clk),
        .rst_n       (rst_n),
        .mode        (mode_all[2*i+1:2*i]),
        .out_data    (pin_out_data[i]),
        .pad_out     (pin_out[i]),
        .pad_oe      (pin_oe[i]),
        .pad_pullup  (pin_pullup_en[i]),
        .pad_schmitt (pin_schmitt_en[i])
      );
    end
  endgenerate

endmodule

//--- sim/port0_pin_mode_control_assertions.sv
// Pad and readback checks for the port 0 pin-mode block
`timescale 1ns/1ns
module port0_pin_mode_control_assertions #(parameter PINS = 8)
(
  input logic            clk, rst_n, reg_rd,
  input logic [7:0]      reg_addr, reg_rdata, pin_out_data,
  input logic [PINS-1:0] pin_out, pin_oe, pin_pullup_en, pin_schmitt_en,
  input logic [15:0]     pin_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle;
    pin_mode[1:0] == 2'h0 |-> pin_schmitt_en[0] && !pin_oe[0] && !pin_pullup_en[0];
  endproperty
  a_idle: assert property (p_idle) else $error("pin 0 not a plain input");
  property p_pull;
    pin_mode[15:14] == 2'h1 |-> pin_pullup_en[7] && pin_schmitt_en[7] && !pin_oe[7];
  endproperty
  a_pull: assert property (p_pull) else $error("pin 7 pull-up wrong");
  property p_od;
    pin_mode[1:0] == 2'h2 |-> !pin_out[0] && pin_oe[0] == !$past(pin_out_data[0]);
  endproperty
  a_od: assert property (p_od) else $error("pin 0 open drain wrong");
  property p_pp;
    pin_mode[15:14] == 2'h3 |-> pin_oe[7] && pin_out[7] == $past(pin_out_data[7]);
  endproperty
  a_pp: assert property (p_pp) else $error("pin 7 push-pull wrong");
  property p_rd;
    reg_rd && reg_addr == 8'he1 |=> reg_rdata == pin_mode[7:0];
  endproperty
  a_rd: assert property (p_rd) else $error("lower readback wrong");
  c_od: cover property (pin_mode[1:0] == 2'h2);
  c_pp: cover property (pin_mode[15:14] == 2'h3);
  c_rd: cover property (reg_rd && reg_addr == 8'he1);
endmodule

//--- sim/pin_board.sv
// Board model resolving each port pin level
`timescale 1ns/1ns
module pin_board
(
  input  logic [7:0] pin_out, pin_oe, pin_pullup_en, ext,
  output logic [7:0] level
);
  // Driver wins, then pull-up; an idle pin follows the outside source
  assign level = pin_oe & pin_out | ~pin_oe & (pin_pullup_en | ext);
endmodule

//--- sim/tb.sv
// Self-checking bench for the port 0 pin-mode block
`timescale 1ns/1ns
module tb;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, pin_out_data = 0, ext = 0, reg_rdata;
  logic [7:0]  pin_out, pin_oe, pin_pullup_en, pin_schmitt_en, lvl;
  logic [15:0] pin_mode, md = 0;
  logic [7:0]  expq[$];
  int          bad_count = 0, num_checks = 0;
  port0_pin_mode_control i_port0_pin_mode_control (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_out_data(pin_out_data), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_schmitt_en(pin_schmitt_en),
    .pin_mode(pin_mode));
  pin_board i_pin_board (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext(ext), .level(lvl));
  initial forever #5 clk = ~clk;
  task chk(input logic [7:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Expected pin level: mode, output data, outside level
  function logic f(input logic [1:0] m, input logic d, e);
    return m[1] ? (m[0] ? d : d & e) : (m[0] | e);
  endfunction
  task acc(input logic w, r, input logic [7:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r)
      expq.push_back(a == 8'he0 ? md[15:8] : a == 8'he1 ? md[7:0] : 8'h00);
    if (w && a == 8'he0)
      md[15:8] = d;
    if (w && a == 8'he1)
      md[7:0] = d;
    @(posedge clk);
  endtask
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk)
    if (rd_q)
      chk(reg_rdata, expq.pop_front());
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(5));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    // Unmapped place ignored on write, reads zero
    for (int i = 0; i < 24; i++)
    begin
      pin_out_data <= $urandom;
      ext <= $urandom;
      acc(0, 1, 8'he0, 0);
      acc(1, 0, 8'he0, i < 4 ? {4{i[1:0]}} : 8'($urandom));
      acc(1, 0, 8'he1, i < 4 ? {4{i[1:0]}} : 8'($urandom));
      acc(1, 0, 8'he2, 8'($urandom));
      acc(0, 1, 8'he2, 0);
      acc(0, 1, 8'he1, 0);
      acc(0, 0, 0, 0);
      @(negedge clk);
      for (int p = 0; p < 8; p++)
      begin
        chk(lvl[p], f(md[2*p +: 2], pin_out_data[p], ext[p]));
        chk({pin_schmitt_en[p], pin_pullup_en[p]}, {~md[2*p+1], ~md[2*p+1] & md[2*p]});
      end
      chk(pin_mode[15:8], md[15:8]);
      chk(pin_mode[7:0], md[7:0]);
      // Next requests start just after a rising edge
      @(posedge clk);
    end
    // Mid-run reset returns every pin to a plain input
    rst_n <= 0;
    md = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    acc(0, 1, 8'he0, 0);
    acc(0, 1, 8'he1, 0);
    acc(0, 0, 0, 0);
    @(negedge clk);
    chk(pin_mode[15:8], 8'h00);
    chk(pin_mode[7:0], 8'h00);
    chk(pin_schmitt_en, 8'hff);
    chk(pin_oe, 8'h00);
    chk(pin_pullup_en, 8'h00);
    give_verdict();
  end
endmodule
bind port0_pin_mode_control port0_pin_mode_control_assertions #(.PINS(PINS)) i_chk
  (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .pin_out_data(pin_out_data), .pin_out(pin_out),
   .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_schmitt_en(pin_schmitt_en),
   .pin_mode(pin_mode));
